// ==== bepgs_defs.svh ====
// Constants for the enable / power-good sequencer.
// Assumes a 40 MHz system clock; all counts are derived from it.
`ifndef BEPGS_DEFS_SVH
`define BEPGS_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BEPGS_CLK_KHZ        40000
`define BEPGS_PG_RISE_US     450
`define BEPGS_PG_RISE_CYC    ((`BEPGS_PG_RISE_US * `BEPGS_CLK_KHZ) / 1000)
`define BEPGS_PG_FALL_US     80
`define BEPGS_PG_FALL_CYC    ((`BEPGS_PG_FALL_US * `BEPGS_CLK_KHZ) / 1000)
`define BEPGS_DLY_MAX_MS     10
// Ticks of the 1 us timebase
`define BEPGS_US_CYC         (`BEPGS_CLK_KHZ / 1000)
// Reference ramp full scale in millivolts (top of the ramp)
`define BEPGS_REF_FULL_MV    16'h0280
// Ramp step per microsecond, in microvolts per us (= mV/ms)
`define BEPGS_SS_R0          16'h00A0
`define BEPGS_SS_R1          16'h017C
`define BEPGS_SS_R2          16'h02F8
`define BEPGS_SS_R3          16'h05DC

// ----------------------------------------------------------------------
// Reset values of the configuration
// ----------------------------------------------------------------------
`define BEPGS_RST_DLY_SEL    3'h0
`define BEPGS_RST_SS_SEL     2'h0
`define BEPGS_RST_FREQ_SEL   3'h0

`endif

// ==== bepgs_pkg.sv ====
// Types for the enable / power-good sequencer.
// Assumes bepgs_defs.svh supplies the numbers.
package bepgs_pkg;

    // Sequencer phases
    typedef enum logic [1:0] {
        BEPGS_OFF   = 2'b00,
        BEPGS_DELAY = 2'b01,
        BEPGS_RAMP  = 2'b10,
        BEPGS_RUN   = 2'b11
    } bepgs_state_t;

    // Configuration held in the undervoltage-reset domain
    typedef struct packed {
        logic [2:0] dly_sel;
        logic [1:0] ss_sel;
        logic [2:0] freq_sel;
    } bepgs_cfg_t;

    // Output comparator flags from the analog side
    typedef struct packed {
        logic above_925;
        logic below_90;
    } bepgs_cmp_t;

endpackage

// ==== bepgs_pg_filter.sv ====
// Power-good timing filter: rise delay, fall de-glitch, forced clears.
// Assumes comparator flags already synchronous to sys_clk.
`timescale 1ns/1ps
`include "bepgs_defs.svh"

module bepgs_pg_filter (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               run,
    input  wire logic               force_low,
    input  wire bepgs_pkg::bepgs_cmp_t cmp,
    output logic                    pg_good
);
    localparam int RISE = `BEPGS_PG_RISE_CYC;
    localparam int FALL = `BEPGS_PG_FALL_CYC;

    logic        good_r, good_nxt;
    logic [14:0] cnt_r, cnt_nxt;

    // Counter restarts whenever the pending condition breaks
    always_comb begin
        good_nxt = good_r;
        cnt_nxt  = 15'h0000;
        if (force_low || !run) begin
            good_nxt = 1'b0;
        end else if (!good_r) begin
            if (cmp.above_925) begin
                cnt_nxt = cnt_r + 15'h0001;
                if (cnt_r == 15'(RISE - 1)) begin
                    good_nxt = 1'b1;
                    cnt_nxt  = 15'h0000;
                end
            end
        end else if (cmp.below_90) begin
            // Short dips reset the count, so only a sustained low drops it
            cnt_nxt = cnt_r + 15'h0001;
            if (cnt_r == 15'(FALL - 1)) begin
                good_nxt = 1'b0;
                cnt_nxt  = 15'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            good_r <= 1'b0;
            cnt_r  <= 15'h0000;
        end else begin
            good_r <= good_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign pg_good = good_r;

    pg_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(good_r) |-> $past(cmp.above_925, 1) && $past(run, 1)
        && $past(cnt_r, 1) == 15'(RISE - 1))
        else $error("power-good rose without the rising condition");
    // Only the last de-glitch count may drop the flag while run is high and no force is applied
    pg_fall_a: assert property (@(posedge sys_clk) disable iff (rst)
        good_r && !force_low && run && cnt_r != 15'(FALL - 1)
        |=> good_r)
        else $error("power-good fell before the de-glitch time");
endmodule

// ==== bepgs_seq.sv ====
// Enable / power-good sequencer of a step-down regulator.
// Assumes all inputs are synchronous to sys_clk; the analog stage
// acts on power_stage_on, ref_mv and freq_sel.
`timescale 1ns/1ps
`include "bepgs_defs.svh"

module bepgs_seq (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  supply_undervoltage_lockout,
    input  wire logic                  enable_in,
    input  wire logic                  thermal_shutdown,
    input  wire bepgs_pkg::bepgs_cfg_t cfg_wr_data,
    input  wire logic                  cfg_wr_en,
    input  wire bepgs_pkg::bepgs_cmp_t output_cmp,
    output logic                       power_stage_on,
    output logic                       low_side_allowed,
    output logic [15:0]                ref_mv,
    output logic [2:0]                 freq_sel,
    output bepgs_pkg::bepgs_cfg_t      cfg_rd_data,
    output logic                       output_in_regulation_flag_o,
    output logic                       output_in_regulation_flag_oe,
    output logic                       enable_status
);
    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Start delay in microseconds, ascending from zero; the product
    // needs 17 bits before the divide or the top code (7) wraps
    function automatic logic [13:0] dly_us(input logic [2:0] s);
        logic [16:0] p;
        p = {14'h0000, s} * 17'(`BEPGS_DLY_MAX_MS * 1000);
        return 14'(p / 17'h00007);
    endfunction

    // Reference step per microsecond in microvolts
    function automatic logic [15:0] ss_step(input logic [1:0] s);
        logic [15:0] v;
        case (s)
            2'h0:    v = `BEPGS_SS_R0;
            2'h1:    v = `BEPGS_SS_R1;
            2'h2:    v = `BEPGS_SS_R2;
            default: v = `BEPGS_SS_R3;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Configuration, reset only by rst and the undervoltage lockout
    // ------------------------------------------------------------------
    bepgs_pkg::bepgs_cfg_t cfg_r, cfg_nxt;
    logic cfg_rst;
    assign cfg_rst = rst || supply_undervoltage_lockout;

    // Enable is deliberately absent here so settings survive it
    always_comb begin
        cfg_nxt = cfg_r;
        if (cfg_wr_en) begin
            cfg_nxt = cfg_wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (cfg_rst) begin
            cfg_r <= '{`BEPGS_RST_DLY_SEL, `BEPGS_RST_SS_SEL,
                       `BEPGS_RST_FREQ_SEL};
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Microsecond timebase
    // ------------------------------------------------------------------
    logic [5:0] tb_r, tb_nxt;
    logic       us_tick;
    assign us_tick = (tb_r == 6'(`BEPGS_US_CYC - 1));

    always_comb begin
        tb_nxt = us_tick ? 6'h00 : tb_r + 6'h01;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    bepgs_pkg::bepgs_state_t st_r, st_nxt;
    logic [13:0] dcnt_r, dcnt_nxt;
    logic [25:0] ref_uv_r, ref_uv_nxt;
    logic        run_ok;
    localparam logic [25:0] REF_FULL_UV =
        26'({10'h000, `BEPGS_REF_FULL_MV} * 26'h00003E8);

    // Power may run only with enable high and no lockout or overtemp
    assign run_ok = enable_in && !supply_undervoltage_lockout
                    && !thermal_shutdown;

    always_comb begin
        st_nxt     = st_r;
        dcnt_nxt   = dcnt_r;
        ref_uv_nxt = ref_uv_r;
        case (st_r)
            bepgs_pkg::BEPGS_OFF: begin
                dcnt_nxt   = 14'h0000;
                ref_uv_nxt = 26'h0000000;
                if (run_ok) begin
                    st_nxt = bepgs_pkg::BEPGS_DELAY;
                end
            end
            bepgs_pkg::BEPGS_DELAY: begin
                if (us_tick) begin
                    dcnt_nxt = dcnt_r + 14'h0001;
                end
                if (dcnt_r >= dly_us(cfg_r.dly_sel)) begin
                    st_nxt = bepgs_pkg::BEPGS_RAMP;
                end
            end
            bepgs_pkg::BEPGS_RAMP: begin
                if (us_tick) begin
                    ref_uv_nxt = ref_uv_r + {10'h000, ss_step(cfg_r.ss_sel)};
                end
                // Clamp the step itself so the reference never overshoots
                if (ref_uv_nxt >= REF_FULL_UV) begin
                    ref_uv_nxt = REF_FULL_UV;
                end
                if (ref_uv_r >= REF_FULL_UV) begin
                    st_nxt     = bepgs_pkg::BEPGS_RUN;
                end
            end
            bepgs_pkg::BEPGS_RUN: begin
                ref_uv_nxt = REF_FULL_UV;
            end
            default: begin
                st_nxt = bepgs_pkg::BEPGS_OFF;
            end
        endcase
        if (!run_ok) begin
            st_nxt = bepgs_pkg::BEPGS_OFF;
        end
    end

    // ------------------------------------------------------------------
    // Output pipeline
    // ------------------------------------------------------------------
    logic        pg_good;
    logic        on_nxt, ls_nxt;
    logic [15:0] ref_nxt;

    always_comb begin
        on_nxt  = (st_nxt != bepgs_pkg::BEPGS_OFF)
                  && (st_nxt != bepgs_pkg::BEPGS_DELAY);
        // Low side held off for the whole ramp so a pre-biased rail is
        // never sunk; costs rectifier efficiency during soft-start
        ls_nxt  = on_nxt && (st_nxt == bepgs_pkg::BEPGS_RUN);
        ref_nxt = 16'(ref_uv_nxt / 26'h00003E8);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tb_r                         <= 6'h00;
            st_r                         <= bepgs_pkg::BEPGS_OFF;
            dcnt_r                       <= 14'h0000;
            ref_uv_r                     <= 26'h0000000;
            power_stage_on               <= 1'b0;
            low_side_allowed             <= 1'b0;
            ref_mv                       <= 16'h0000;
            freq_sel                     <= `BEPGS_RST_FREQ_SEL;
            cfg_rd_data                  <= '0;
            output_in_regulation_flag_o  <= 1'b0;
            output_in_regulation_flag_oe <= 1'b1;
            enable_status                <= 1'b0;
        end else begin
            tb_r                         <= tb_nxt;
            st_r                         <= st_nxt;
            dcnt_r                       <= dcnt_nxt;
            ref_uv_r                     <= ref_uv_nxt;
            power_stage_on               <= on_nxt;
            low_side_allowed             <= ls_nxt;
            ref_mv                       <= ref_nxt;
            freq_sel                     <= cfg_r.freq_sel;
            cfg_rd_data                  <= cfg_r;
            output_in_regulation_flag_o  <= 1'b0;
            output_in_regulation_flag_oe <= !pg_good;
            enable_status                <= enable_in;
        end
    end

    // Forced clears bypass the filter delays entirely
    bepgs_pg_filter u_pg (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .run       (enable_in),
        .force_low (supply_undervoltage_lockout || thermal_shutdown),
        .cmp       (output_cmp),
        .pg_good   (pg_good)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence en_drop_s;
        !enable_in;
    endsequence

    en_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
        en_drop_s |=> !power_stage_on)
        else $error("power stage still on after enable low");
    cfg_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        !supply_undervoltage_lockout && !cfg_wr_en
        |=> cfg_r == $past(cfg_r))
        else $error("configuration changed without a write");
    cfg_supply_undervoltage_lockout_a: assert property (@(posedge sys_clk) disable iff (rst)
        supply_undervoltage_lockout
        |=> cfg_r == {`BEPGS_RST_DLY_SEL, `BEPGS_RST_SS_SEL,
                      `BEPGS_RST_FREQ_SEL})
        else $error("configuration not held in lockout");
    dly_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        st_r == bepgs_pkg::BEPGS_DELAY && cfg_r.dly_sel == 3'h0 && run_ok
        |=> st_r == bepgs_pkg::BEPGS_RAMP)
        else $error("zero start delay not honoured");
    ramp_up_a: assert property (@(posedge sys_clk) disable iff (rst)
        st_r == bepgs_pkg::BEPGS_RAMP && run_ok
        |=> ref_uv_r >= $past(ref_uv_r) && ref_uv_r <= REF_FULL_UV)
        else $error("reference ramp went down or overshot");
    freq_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> freq_sel == $past(cfg_r.freq_sel))
        else $error("frequency select does not follow setting");
    pg_en_a: assert property (@(posedge sys_clk) disable iff (rst)
        !enable_in ##1 1'b1 |=> output_in_regulation_flag_oe)
        else $error("power-good not cleared on enable low");
    pg_fault_a: assert property (@(posedge sys_clk) disable iff (rst)
        (thermal_shutdown || supply_undervoltage_lockout)
        ##2 1'b1 |-> output_in_regulation_flag_oe)
        else $error("power-good not cleared on fault");
    od_a: assert property (@(posedge sys_clk) disable iff (rst)
        output_in_regulation_flag_o == 1'b0)
        else $error("power-good driven high");
    prebias_a: assert property (@(posedge sys_clk) disable iff (rst)
        st_r != bepgs_pkg::BEPGS_RUN |-> !low_side_allowed)
        else $error("low side allowed before the ramp ended");
endmodule

// ==== bepgs_stage_model.sv ====
// Behavioural power stage, output comparators and power-good pull-up.
// Assumes ref_mv in millivolts and a 640 mV regulation target.
`timescale 1ns/1ps

module bepgs_stage_model (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             power_stage_on,
    input  wire logic [15:0]      ref_mv,
    input  wire logic             pg_oe,
    input  wire logic             pg_o,
    input  wire logic             dip,
    output bepgs_pkg::bepgs_cmp_t output_cmp,
    output logic                  pg_line
);
    logic [15:0] vout_r;
    logic [15:0] vout_nxt;

    // ------------------------------------------------------------------
    // Output rail
    // ------------------------------------------------------------------
    // Rail only follows the reference upward; with the stage off the
    // capacitors keep their charge, so a restart meets a pre-biased rail
    always_comb begin
        vout_nxt = vout_r;
        if (rst) begin
            vout_nxt = 16'h0000;
        end else if (power_stage_on && ref_mv > vout_r) begin
            vout_nxt = ref_mv;
        end
    end

    always_ff @(posedge sys_clk) begin
        vout_r <= vout_nxt;
    end

    // Thresholds 592 and 576 mV; dip stands for a load-step sag
    assign output_cmp.above_925 = !dip && vout_r >= 16'h0250;
    assign output_cmp.below_90  = dip || vout_r < 16'h0240;
    // Open drain: the pin level while pulled, else the external pull-up
    assign pg_line = pg_oe ? pg_o : 1'b1;
endmodule

// ==== buck_enable_powergood_sequencer_test.sv ====
// Self-checking bench for the enable / power-good sequencer.
// Assumes bepgs_stage_model as far side and a 40 MHz clock.
`timescale 1ns/1ps
`include "bepgs_defs.svh"

module buck_enable_powergood_sequencer_test;
    typedef struct {
        int          sel;
        logic [15:0] exp;
    } bepgs_note_t;

    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  supply_undervoltage_lockout = 1'b0;
    logic                  enable_in = 1'b0;
    logic                  thermal_shutdown = 1'b0;
    bepgs_pkg::bepgs_cfg_t cfg_wr_data = 8'h00;
    logic                  cfg_wr_en = 1'b0;
    logic                  dip = 1'b0;
    bepgs_pkg::bepgs_cmp_t output_cmp;
    logic                  power_stage_on;
    logic [15:0]           ref_mv;
    logic [2:0]            freq_sel;
    bepgs_pkg::bepgs_cfg_t cfg_rd_data;
    logic                  pg_o;
    logic                  pg_oe;
    logic                  enable_status;
    logic                  pg_line;
    logic                  low_side_allowed;
    bepgs_note_t           notes[$];
    event                  take;
    int                    miscompares = 0;
    int                    compares = 0;
    int                    pending = 0;
    int                    seed = 32'h0440;
    string names[9] = '{"cfg_rd_data", "freq_sel", "pg_oe",
                        "power_stage_on", "ref_mv", "pg_line",
                        "enable_status", "output_cmp", "low_side_allowed"};

    always #12.5 sys_clk = ~sys_clk;

    bepgs_seq dut (
        .sys_clk                      (sys_clk),
        .rst                          (rst),
        .supply_undervoltage_lockout  (supply_undervoltage_lockout),
        .enable_in                    (enable_in),
        .thermal_shutdown             (thermal_shutdown),
        .cfg_wr_data                  (cfg_wr_data),
        .cfg_wr_en                    (cfg_wr_en),
        .output_cmp                   (output_cmp),
        .power_stage_on               (power_stage_on),
        .low_side_allowed             (low_side_allowed),
        .ref_mv                       (ref_mv),
        .freq_sel                     (freq_sel),
        .cfg_rd_data                  (cfg_rd_data),
        .output_in_regulation_flag_o  (pg_o),
        .output_in_regulation_flag_oe (pg_oe),
        .enable_status                (enable_status)
    );

    bepgs_stage_model stage (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .power_stage_on (power_stage_on),
        .ref_mv         (ref_mv),
        .pg_oe          (pg_oe),
        .pg_o           (pg_o),
        .dip            (dip),
        .output_cmp     (output_cmp),
        .pg_line        (pg_line)
    );

    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    function automatic logic [15:0] obs(int sel);
        case (sel)
            0: obs = {8'h00, cfg_rd_data};
            1: obs = {13'h0000, freq_sel};
            2: obs = {15'h0000, pg_oe};
            3: obs = {15'h0000, power_stage_on};
            4: obs = ref_mv;
            5: obs = {15'h0000, pg_line};
            6: obs = {15'h0000, enable_status};
            7: obs = {14'h0000, output_cmp};
            default: obs = {15'h0000, low_side_allowed};
        endcase
    endfunction

    // Oldest note is compared whenever the driver presents a result
    always @(take) begin
        bepgs_note_t t;
        while (notes.size() > 0) begin
            t = notes.pop_front();
            compares++;
            if (obs(t.sel) !== t.exp) begin
                miscompares++;
                $display("unexpected %s: expected %h, seen %h",
                         names[t.sel], t.exp, obs(t.sel));
            end
            pending--;
        end
    end

    task automatic finish_test();
        $display("compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Waiting on the monitor keeps the next stimulus on the falling edge
    task automatic check(int sel, logic [15:0] exp);
        pending++;
        notes.push_back('{sel, exp});
        -> take;
        wait (pending == 0);
    endtask

    task automatic span(int n, int lo, int hi);
        compares++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("unexpected cycles: expected %0d..%0d, seen %0d",
                     lo, hi, n);
        end
    endtask

    // Bounded wait; running out ends the run as a mismatch
    task automatic wait_for(int sel, logic [15:0] exp, int lim,
                            output int n);
        n = 0;
        while (obs(sel) !== exp && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        compares++;
        if (obs(sel) !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h after %0d",
                     names[sel], exp, obs(sel), n);
            finish_test();
        end
    endtask

    task automatic write_cfg(bepgs_pkg::bepgs_cfg_t w);
        cfg_wr_data = w;
        cfg_wr_en = 1'b1;
        @(negedge sys_clk);
        cfg_wr_en = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        bepgs_pkg::bepgs_cfg_t w;
        int n;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        check(0, 16'h0000);
        check(1, 16'h0000);
        check(2, 16'h0001);
        check(5, 16'h0000);
        // Every frequency code, random delay and rate fields beside it
        for (int i = 0; i < 8; i++) begin
            w = 8'($random(seed));
            w.freq_sel = 3'(i);
            write_cfg(w);
            check(0, {8'h00, w});
            check(1, {13'h0000, w.freq_sel});
        end
        // Longest start delay: power must stay off through a short enable
        w = '{dly_sel: 3'h7, ss_sel: 2'h3, freq_sel: 3'h5};
        write_cfg(w);
        enable_in = 1'b1;
        repeat (40) @(negedge sys_clk);
        check(3, 16'h0000);
        check(6, 16'h0001);
        enable_in = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(6, 16'h0000);
        check(0, {8'h00, w});
        // Writes during lockout are dropped and the copy is cleared
        supply_undervoltage_lockout = 1'b1;
        write_cfg(w);
        check(0, 16'h0000);
        supply_undervoltage_lockout = 1'b0;
        @(negedge sys_clk);
        check(0, 16'h0000);
        w.dly_sel = 3'h0;
        write_cfg(w);
        enable_in = 1'b1;
        wait_for(3, 16'h0001, 8, n);
        wait_for(7, 16'h0002, 20000, n);
        span(n, 15000, 16500);
        wait_for(2, 16'h0000, 20000, n);
        span(n, `BEPGS_PG_RISE_CYC - 2, `BEPGS_PG_RISE_CYC + 4);
        check(4, 16'h0280);
        check(5, 16'h0001);
        check(8, 16'h0001);
        // A short sag is ignored, a long one drops power-good
        dip = 1'b1;
        repeat (2000) @(negedge sys_clk);
        dip = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(2, 16'h0000);
        dip = 1'b1;
        wait_for(2, 16'h0001, 4000, n);
        span(n, `BEPGS_PG_FALL_CYC - 2, `BEPGS_PG_FALL_CYC + 4);
        dip = 1'b0;
        // Thermal shutdown, then lockout, each with power-good up
        for (int f = 0; f < 2; f++) begin
            wait_for(2, 16'h0000, 20000, n);
            if (f == 0) begin
                thermal_shutdown = 1'b1;
            end else begin
                supply_undervoltage_lockout = 1'b1;
            end
            wait_for(2, 16'h0001, 3, n);
            wait_for(3, 16'h0000, 3, n);
            thermal_shutdown = 1'b0;
            supply_undervoltage_lockout = 1'b0;
            @(negedge sys_clk);
            // Restart meets the rail still charged: no sinking allowed
            wait_for(3, 16'h0001, 8, n);
            check(8, 16'h0000);
        end
        check(0, 16'h0000);
        wait_for(2, 16'h0000, 20000, n);
        enable_in = 1'b0;
        wait_for(2, 16'h0001, 3, n);
        wait_for(3, 16'h0000, 3, n);
        finish_test();
    end
endmodule
